// file: design/nvc_ctrl.sv
// nonvolatile memory control, commit sequencing and live checksum
// Behaviour
// R1 - bit6 write copies registers to sram
// R2 - bit6 self-clears when copy done
// R3 - sram page from page-select register
// R4 - checksum mismatch on load sets bit5
// R5 - bit4 set: program writes checksum byte
// R6 - bit3 loads eeprom, then self-clears
// R7 - load runs automatically after reset
// R8 - reads blocked during load
// R9 - load only while aux clock runs; code checks aux only when a load starts, a running load continues
// R10 - host keeps aux clock after lock
// R11 - bit2 busy throughout program cycle
// R12 - eeprom accesses blocked while busy
// R13 - bit0 starts program, self-clears
// R14 - program needs unlock write just before
// R15 - program cycle lasts 230 ms
// R16 - 8-bit live checksum register, reset zero
// R17 - program counter increments, saturates 255
// R18 - locked program request ignored
// R19 - bit7 zero, bit1 self-clears inertly
`include "nvc_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module nvc_ctrl #(
  parameter int          AW         = 4,
  parameter int          PROG_CYC   = `NVC_PROG_CYCLES,
  parameter logic [7:0]  UNLOCK_KEY = 8'hA5  // arbitrary unlock value
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       host_wr,
  input  wire logic       host_rd,
  input  wire logic       host_txn_end,
  input  wire logic [7:0] host_addr,
  input  wire logic [7:0] host_wdata,
  output logic      [7:0] host_rdata,
  output logic            host_rd_valid,
  output logic            host_rd_blocked,
  input  wire logic       aux_clk_running,
  input  wire logic       keep_aux_clock_after_lock,
  input  wire logic [7:0] cfg_in,
  output logic      [7:0] cfg_out,
  output logic            cfg_load_strobe,
  output logic      [7:0] cfg_load_idx
);
  localparam int N = 1 << AW;

  typedef struct packed {
    nvc_pkg::nvc_state_t st;
    logic [AW:0]  idx;
    logic [31:0]  tmr;
    logic [7:0]   sum;
    logic         rd_pend;
    logic         reg_to_sram_copy_trigger;
    logic         stored_checksum_mismatch_flag;
    logic         auto_checksum_on_program;
    logic         eeprom_to_reg_load_trigger;
    logic         erase_program_trigger;
    logic         rsv1;
    logic         unlocked;
    logic         sram_dest_page_select;
    logic [7:0]   live_checksum;
    logic [7:0]   program_cycle_count;
    logic [7:0]   rdata;
    logic         rvalid;
    logic         boot;
  } nvc_s_t;

  nvc_s_t r;
  nvc_s_t next_r;
  nvc_mem_if #(.AW(AW)) mem ();

  nvc_arrays #(.AW(AW)) u_arr (
    .ref_clk (ref_clk),
    .mem     (mem)
  );

  // checksum byte update, crc-8 poly 0x07
  function automatic logic [7:0] nvc_crc(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int i = 0; i < 8; i++) begin
      x = x[7] ? ((x << 1) ^ 8'h07) : (x << 1);
    end
    return x;
  endfunction : nvc_crc

  wire logic busy = (r.st == nvc_pkg::NVC_PROG) || (r.st == nvc_pkg::NVC_SUM);  // see R11
  wire logic [AW-1:0] ia = r.idx[AW-1:0];

  // ==================================================
  // memory port
  always_comb begin
    // load reads one byte ahead to match the registered array read
    mem.addr       = (r.st == nvc_pkg::NVC_LOAD) ? ia + AW'(r.rd_pend) : ia;
    mem.ee_we      = 1'b0;
    mem.ee_wdata   = 8'h00;
    mem.sram_we    = 1'b0;
    mem.sram_wdata = cfg_in;
    mem.sram_addr  = {r.sram_dest_page_select, ia};  // see R3
    if (r.st == nvc_pkg::NVC_COPY) begin
      mem.sram_we = 1'b1;  // see R1
    end
    if (r.st == nvc_pkg::NVC_SUM && r.rd_pend) begin
      mem.ee_we     = 1'b1;  // see R13
      mem.ee_wdata  = mem.sram_rdata;
      mem.sram_addr = {r.sram_dest_page_select, ia + AW'(1)};
      if (r.auto_checksum_on_program && r.idx == (AW+1)'(N - 1)) begin
        mem.ee_wdata = r.sum;  // see R5
      end
    end
  end

  // ==================================================
  // next state
  always_comb begin
    next_r = r;
    next_r.rvalid = 1'b0;
    next_r.rsv1   = 1'b0;  // see R19
    if (host_txn_end) begin
      next_r.unlocked = host_wr && host_addr == `NVC_UNLOCK_OFFSET && host_wdata == UNLOCK_KEY;  // see R14
    end
    if (host_wr && host_addr == `NVC_PAGE_OFFSET) begin
      next_r.sram_dest_page_select = host_wdata[0];
    end
    if (host_wr && host_addr == `NVC_CTL_OFFSET) begin
      next_r.auto_checksum_on_program = host_wdata[`NVC_BIT_AUTOCRC];
      if (host_wdata[`NVC_BIT_REGCOPY] && r.st == nvc_pkg::NVC_IDLE) begin
        next_r.reg_to_sram_copy_trigger = 1'b1;
      end
      if (host_wdata[`NVC_BIT_LOAD] && r.st == nvc_pkg::NVC_IDLE) begin  // see R12
        next_r.eeprom_to_reg_load_trigger = 1'b1;
      end
      if (host_wdata[`NVC_BIT_PROG] && r.unlocked && !busy) begin  // see R18
        next_r.erase_program_trigger = 1'b1;
      end
    end
    if (host_rd && !(r.st == nvc_pkg::NVC_LOAD)) begin  // see R8
      next_r.rvalid = 1'b1;
      case (host_addr)
        `NVC_CTL_OFFSET:  next_r.rdata = {1'b0, r.reg_to_sram_copy_trigger, r.stored_checksum_mismatch_flag,
                                          r.auto_checksum_on_program, r.eeprom_to_reg_load_trigger, busy,
                                          r.rsv1, r.erase_program_trigger};  // see R19
        `NVC_LCRC_OFFSET: next_r.rdata = r.live_checksum;  // see R16
        `NVC_CNT_OFFSET:  next_r.rdata = r.program_cycle_count;
        default:          next_r.rdata = 8'h00;
      endcase
    end
    case (r.st)
      nvc_pkg::NVC_IDLE: begin
        next_r.idx = '0;
        next_r.rd_pend = 1'b0;
        next_r.sum = 8'h00;
        if (r.boot || r.eeprom_to_reg_load_trigger) begin
          if (aux_clk_running) begin  // see R9
            next_r.st = nvc_pkg::NVC_LOAD;  // see R7
            next_r.boot = 1'b0;
          end else begin
            next_r.eeprom_to_reg_load_trigger = 1'b0;
          end
        end else if (r.erase_program_trigger) begin
          next_r.erase_program_trigger = 1'b0;  // see R13
          next_r.st  = nvc_pkg::NVC_PROG;
          next_r.tmr = 32'(PROG_CYC - 1);
        end else if (r.reg_to_sram_copy_trigger) begin
          next_r.st = nvc_pkg::NVC_COPY;
        end
      end
      nvc_pkg::NVC_LOAD: begin
        next_r.rd_pend = 1'b1;
        if (r.rd_pend) begin
          next_r.sum = nvc_crc(r.sum, mem.ee_rdata);
          if (r.idx == (AW+1)'(N - 1)) begin
            next_r.live_checksum = r.sum;  // see R16
            next_r.stored_checksum_mismatch_flag = (mem.ee_rdata != r.sum);  // see R4
            next_r.eeprom_to_reg_load_trigger = 1'b0;  // see R6
            next_r.st = nvc_pkg::NVC_IDLE;
          end
          next_r.idx = r.idx + 1'b1;
        end
      end
      nvc_pkg::NVC_COPY: begin
        next_r.idx = r.idx + 1'b1;
        if (r.idx == (AW+1)'(N - 1)) begin
          next_r.reg_to_sram_copy_trigger = 1'b0;  // see R2
          next_r.st = nvc_pkg::NVC_IDLE;
        end
      end
      nvc_pkg::NVC_PROG: begin
        next_r.tmr = r.tmr - 32'd1;  // see R15
        if (r.tmr == 32'd0) begin
          if (r.program_cycle_count != `NVC_CNT_MAX) begin
            next_r.program_cycle_count = r.program_cycle_count + 8'h01;  // see R17
          end
          next_r.idx = '0;
          next_r.tmr = 32'd1;
          next_r.rd_pend = 1'b0;
          next_r.st = nvc_pkg::NVC_SUM;  // sram page is written into the eeprom next
        end
      end
      nvc_pkg::NVC_SUM: begin
        next_r.rd_pend = 1'b1;
        if (r.rd_pend) begin
          next_r.sum = nvc_crc(r.sum, mem.sram_rdata);
          next_r.idx = r.idx + 1'b1;
          if (r.idx == (AW+1)'(N - 1)) begin
            next_r.st = nvc_pkg::NVC_IDLE;
          end
        end
      end
      default: next_r.st = nvc_pkg::NVC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      r <= '0;
      r.st <= nvc_pkg::NVC_IDLE;
      r.auto_checksum_on_program <= `NVC_AUTOCRC_RESET;
      r.live_checksum <= `NVC_LCRC_RESET;
      r.boot <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ==================================================
  // outputs
  assign host_rdata      = r.rdata;
  assign host_rd_valid   = r.rvalid;
  assign host_rd_blocked = (r.st == nvc_pkg::NVC_LOAD);  // see R8
  assign cfg_out         = mem.ee_rdata;
  assign cfg_load_strobe = (r.st == nvc_pkg::NVC_LOAD) && r.rd_pend;
  assign cfg_load_idx    = 8'(r.idx);

  // keep_aux_clock_after_lock is a host-side setting that keeps aux_clk_running high; see R10
  wire logic unused_keep = keep_aux_clock_after_lock;
endmodule : nvc_ctrl
`default_nettype wire

// file: inc/nvc_regs.svh
// register offsets, fields, reset values and timing counts of the nonvolatile memory controller
`ifndef NVC_REGS_SVH
`define NVC_REGS_SVH
`define NVC_CTL_OFFSET      8'h89
`define NVC_LCRC_OFFSET     8'h8A
`define NVC_CNT_OFFSET      8'h88
`define NVC_UNLOCK_OFFSET   8'h90
`define NVC_PAGE_OFFSET     8'h91
`define NVC_BIT_REGCOPY     6
`define NVC_BIT_CRCERR      5
`define NVC_BIT_AUTOCRC     4
`define NVC_BIT_LOAD        3
`define NVC_BIT_BUSY        2
`define NVC_BIT_RSV1        1
`define NVC_BIT_PROG        0
`define NVC_AUTOCRC_RESET   1'b1
`define NVC_LCRC_RESET      8'h00
`define NVC_CNT_MAX         8'hFF
`define NVC_PROG_TIME_MS    230
`define NVC_CLK_HZ          10000000
`define NVC_PROG_CYCLES     (`NVC_PROG_TIME_MS * (`NVC_CLK_HZ / 1000))
`endif

// file: inc/nvc_pkg.sv
// types of the nonvolatile memory controller
package nvc_pkg;
  typedef enum logic [2:0] {
    NVC_IDLE,
    NVC_LOAD,
    NVC_COPY,
    NVC_PROG,
    NVC_SUM
  } nvc_state_t;
endpackage : nvc_pkg

// file: inc/nvc_mem_if.sv
// array access port between the controller and its memory arrays
`timescale 1ns/100ps
`default_nettype none
interface nvc_mem_if #(parameter int AW = 4);
  logic          ee_we;
  logic [AW-1:0] addr;
  logic [7:0]    ee_wdata;
  logic [7:0]    ee_rdata;
  logic          sram_we;
  logic [7:0]    sram_wdata;
  logic [AW:0]   sram_addr;
  logic [7:0]    sram_rdata;
  modport ctl (output ee_we, addr, ee_wdata, sram_we, sram_wdata, sram_addr, input ee_rdata, sram_rdata);
  modport mem (input ee_we, addr, ee_wdata, sram_we, sram_wdata, sram_addr, output ee_rdata, sram_rdata);
endinterface : nvc_mem_if
`default_nettype wire

// file: design/nvc_arrays.sv
// eeprom model array and sram shadow with two pages
`timescale 1ns/100ps
`default_nettype none
module nvc_arrays #(
  parameter int AW = 4
) (
  input  wire logic ref_clk,
  nvc_mem_if.mem    mem
);
  logic [7:0] ee   [0:(1<<AW)-1];
  logic [7:0] sram [0:(1<<(AW+1))-1];
  logic [7:0] rd;
  logic [7:0] rs;

  always_ff @(posedge ref_clk) begin
    if (mem.ee_we) begin
      ee[mem.addr] <= mem.ee_wdata;
    end
    if (mem.sram_we) begin
      sram[mem.sram_addr] <= mem.sram_wdata;
    end
    rd <= ee[mem.addr];
    rs <= sram[mem.sram_addr];
  end

  assign mem.ee_rdata   = rd;
  assign mem.sram_rdata = rs;
endmodule : nvc_arrays
`default_nettype wire

// file: verif/nvc_ctrl_chk.sv
// port checker of the nonvolatile memory controller
`timescale 1ns/100ps
`default_nettype none
module nvc_ctrl_chk (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       host_rd,
  input wire logic [7:0] host_addr,
  input wire logic [7:0] host_rdata,
  input wire logic       host_rd_valid,
  input wire logic       host_rd_blocked,
  input wire logic       aux_clk_running,
  input wire logic       cfg_load_strobe
);
  // ====
  // host read path and load sequencing
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  chk_read_answered: assert property (host_rd && !host_rd_blocked |=> host_rd_valid)
    else $error("read not answered");
  chk_blocked_silent: assert property (host_rd && host_rd_blocked |=> !host_rd_valid)
    else $error("read answered during load");
  chk_valid_cause: assert property (host_rd_valid |-> $past(host_rd))
    else $error("answer without request");
  chk_bit7_zero: assert property (host_rd_valid && $past(host_addr) == 8'h89 |-> !host_rdata[7])
    else $error("status bit 7 set");
  chk_bit1_zero: assert property (host_rd_valid && $past(host_addr) == 8'h89 |-> !host_rdata[1])
    else $error("status bit 1 set");
  chk_boot_load: assert property ($rose(rst_n) && aux_clk_running |-> ##[0:4] host_rd_blocked)
    else $error("no load after reset");
  chk_load_ends: assert property ($rose(host_rd_blocked) |-> ##[1:80] !host_rd_blocked)
    else $error("load does not end");
  chk_load_aux: assert property (cfg_load_strobe |-> aux_clk_running && host_rd_blocked)
    else $error("load byte outside running load");
endmodule : nvc_ctrl_chk
`default_nettype wire

// file: verif/nvc_host_model.sv
// host side model: register accesses and config byte source
`timescale 1ns/100ps
`default_nettype none
module nvc_host_model (
  input  wire logic       ref_clk,
  input  wire logic       host_rd_valid,
  input  wire logic       host_rd_blocked,
  input  wire logic [7:0] host_rdata,
  input  wire logic [7:0] cfg_load_idx,
  output var logic        host_wr,
  output var logic        host_rd,
  output var logic        host_txn_end,
  output var logic  [7:0] host_addr,
  output var logic  [7:0] host_wdata,
  output logic      [7:0] cfg_in
);
  // ====
  // bus tasks, each access is one transaction
  assign cfg_in = cfg_load_idx ^ 8'h3C;
  initial begin
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_txn_end = 1'b0;
    host_addr = 8'h00;
    host_wdata = 8'h00;
  end
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    host_wr <= 1'b1;
    host_addr <= a;
    host_wdata <= d;
    host_txn_end <= 1'b1;
    @(posedge ref_clk);
    host_wr <= 1'b0;
    host_txn_end <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    n = 0;
    while (host_rd_blocked !== 1'b0 && n < 200) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    @(posedge ref_clk);
    host_rd <= 1'b1;
    host_addr <= a;
    host_txn_end <= 1'b1;
    @(posedge ref_clk);
    host_rd <= 1'b0;
    host_txn_end <= 1'b0;
    #1;
    d = host_rd_valid ? host_rdata : 8'hXX;
  endtask : rd
endmodule : nvc_host_model
`default_nettype wire

// file: verif/tb_nvm_control_and_live_crc.sv
// self-checking bench of the nonvolatile memory controller
`timescale 1ns/100ps
`default_nettype none
module tb_nvm_control_and_live_crc;
  logic ref_clk, rst_n, aux_clk_running, host_wr, host_rd, host_txn_end, host_rd_valid, host_rd_blocked;
  logic cfg_load_strobe, watch;
  logic [7:0] host_addr, host_wdata, host_rdata, cfg_in, cfg_out, cfg_load_idx, v, cnt;
  int errors, comparisons, cycles, strobes;
  nvc_ctrl #(.PROG_CYC(50)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .host_wr(host_wr), .host_rd(host_rd),
    .host_txn_end(host_txn_end), .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .host_rd_valid(host_rd_valid), .host_rd_blocked(host_rd_blocked), .aux_clk_running(aux_clk_running),
    .keep_aux_clock_after_lock(1'b1), .cfg_in(cfg_in), .cfg_out(cfg_out), .cfg_load_strobe(cfg_load_strobe),
    .cfg_load_idx(cfg_load_idx));
  nvc_host_model host (.ref_clk(ref_clk), .host_rd_valid(host_rd_valid), .host_rd_blocked(host_rd_blocked),
    .host_rdata(host_rdata), .cfg_load_idx(cfg_load_idx), .host_wr(host_wr), .host_rd(host_rd),
    .host_txn_end(host_txn_end), .host_addr(host_addr), .host_wdata(host_wdata), .cfg_in(cfg_in));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  // crc-8, polynomial 0x07, over the config bytes
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int i = 0; i < 8; i++) begin
      x = x[7] ? ((x << 1) ^ 8'h07) : (x << 1);
    end
    return x;
  endfunction : crc8
  task final_report;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  // ====
  // loaded bytes must be the copied config, checksum byte excluded
  always @(posedge ref_clk) begin
    cycles++;
    if (cfg_load_strobe === 1'b1) strobes++;
    if (cfg_load_strobe === 1'b1 && watch && cfg_load_idx < 8'h0F) cmp("cfg_out", cfg_load_idx ^ 8'h3C, cfg_out);
    if (cycles > 20000) begin
      errors++;
      final_report();
    end
  end
  task poll(input int bitn);
    int n;
    n = 0;
    host.rd(8'h89, v);
    while (v[bitn] !== 1'b0 && n < 100) begin
      host.rd(8'h89, v);
      n++;
    end
  endtask : poll
  task t_locked;
    host.wr(8'h89, 8'h93);
    host.rd(8'h89, v);
    cmp("status", 8'h10, v & 8'hDF);
  endtask : t_locked
  task t_copy_prog_load;
    host.wr(8'h89, 8'h50);
    poll(6);
    cmp("copy", 8'h00, v & 8'h40);
    host.rd(8'h88, cnt);
    host.wr(8'h90, 8'hA5);
    host.wr(8'h89, 8'h11);
    host.rd(8'h89, v);
    cmp("busy", 8'h04, v & 8'h05);
    poll(2);
    cmp("busy_end", 8'h00, v & 8'h04);
    host.rd(8'h88, v);
    cmp("count", (cnt == 8'hFF) ? cnt : cnt + 8'h01, v);
    watch = 1'b1;
    host.wr(8'h89, 8'h18);
    repeat (3) @(posedge ref_clk);
    host.rd(8'h89, v);
    cmp("load", 8'h10, v);
    watch = 1'b0;
  endtask : t_copy_prog_load
  task t_nocrc;
    int i;
    logic [7:0] s;
    s = 8'h00;
    for (i = 0; i < 15; i++) begin
      s = crc8(s, 8'(i) ^ 8'h3C);
    end
    host.rd(8'h8A, v);
    cmp("live_sum", s, v);
    host.wr(8'h90, 8'hA5);
    host.wr(8'h89, 8'h01);
    poll(2);
    watch = 1'b1;
    host.wr(8'h89, 8'h08);
    repeat (3) @(posedge ref_clk);
    host.rd(8'h89, v);
    watch = 1'b0;
    cmp("crc_err", 8'h20, v);
    host.rd(8'h8A, v);
    cmp("live_sum2", s, v);
  endtask : t_nocrc
  task t_aux_off;
    @(posedge ref_clk);
    aux_clk_running <= 1'b0;
    cnt = strobes[7:0];
    host.wr(8'h89, 8'h18);
    repeat (5) @(posedge ref_clk);
    host.rd(8'h89, v);
    cmp("no_load", 8'h10, v & 8'hDF);
    cmp("strobes", cnt, strobes[7:0]);
  endtask : t_aux_off
  initial begin
    rst_n = 1'b0;
    aux_clk_running = 1'b1;
    watch = 1'b0;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    host.rd(8'h89, v);
    cmp("boot", 8'h10, v & 8'hDF);
    t_locked();
    t_copy_prog_load();
    t_nocrc();
    t_aux_off();
    final_report();
  end
endmodule : tb_nvm_control_and_live_crc
bind nvc_ctrl nvc_ctrl_chk chk (.ref_clk(ref_clk), .rst_n(rst_n), .host_rd(host_rd), .host_addr(host_addr),
  .host_rdata(host_rdata), .host_rd_valid(host_rd_valid), .host_rd_blocked(host_rd_blocked),
  .aux_clk_running(aux_clk_running), .cfg_load_strobe(cfg_load_strobe));
`default_nettype wire
